//--- shared/bmsi_defs.vh
`ifndef BMSI_DEFS_VH
`define BMSI_DEFS_VH

// Boot mode codes seen on port zero low bits [5:4]
`define BMSI_MODE_HI       5
`define BMSI_MODE_LO       4
`define BMSI_MODE_ALT      2'b01
`define BMSI_MODE_BSL      2'b10
`define BMSI_MODE_NORMAL   2'b11
// Bus type field source bits on port zero low
`define BMSI_BUS_TYPE_FIELD_HI       7
`define BMSI_BUS_TYPE_FIELD_LO       6

// Boot-mode register load values
`define BMSI_CP_BOOT       16'hfa00
`define BMSI_STACK_UNDERFLOW_LIMIT_BOOT    16'hfa00
`define BMSI_SP_BOOT       16'hfa40
`define BMSI_STACK_OVERFLOW_LIMIT_BOOT    16'hfc00
`define BMSI_SYSTEM_CONFIG_REG_BOOT   16'h0404
`define BMSI_XPER_BOOT     16'h002d
`define BMSI_ZERO16        16'h0000

// System configuration fields
`define BMSI_SYS_EXT_PERIPH_ENABLE_BIT      2
`define BMSI_SYS_BYTE_HIGH_DISABLE_BIT    9
`define BMSI_SYS_INTERNAL_MEM_ENABLE_BIT     10
// Bus control zero fields
`define BMSI_BUS_ACT       10
`define BMSI_BUS_ALE       9
`define BMSI_BUS_TYP_HI    7
`define BMSI_BUS_TYP_LO    6
// Extension peripheral select fields
`define BMSI_XP_CAN1       0
`define BMSI_XP_XRAM1      2
`define BMSI_XP_XRAM2      3
`define BMSI_XP_EXTENSION_USER_FLASH     5
// Emulation control alternate-boot flag
`define BMSI_EMU_ABM       5

// Address map, 24-bit byte addresses
`define BMSI_TFL_LO        24'h000000
`define BMSI_TFL_HI        24'h007fff
`define BMSI_IFL_LO        24'h010000
`define BMSI_IFL_HI        24'h08ffff
`define BMSI_XFL_LO        24'h090000
`define BMSI_XFL_HI        24'h0dffff
`define BMSI_EXTENSION_RAM_LO       24'h0e0000
`define BMSI_EXTENSION_RAM_HI       24'h0effff
`define BMSI_XPER_LO       24'h00e800
`define BMSI_XPER_HI       24'h00efff
`define BMSI_B2B0_LO       24'h0c0000
`define BMSI_B2B0_HI       24'h0c3fff
`define BMSI_ALT_START     24'h090000
`define BMSI_STD_START     24'h000000

`endif

//--- rtl/bmsi_boot_init.v
`include "bmsi_defs.vh"

module bmsi_boot_init (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire        reset_input_pin_n,
  input  wire [7:0]  port_zero_low_config,
  input  wire        external_access_pin_n,
  input  wire        sw_reset_req,
  input  wire        wdt_reset_req,
  input  wire        end_of_init_instruction_exec,
  input  wire        system_config_reg_wr,
  input  wire        xper_wr,
  input  wire [15:0] cfg_wdata,
  input  wire        acc_valid,
  input  wire [23:0] acc_addr,
  input  wire        acc_fetch,
  input  wire        prog_req,
  input  wire [23:0] prog_addr,
  input  wire        sig_start,
  input  wire [15:0] sig_op0,
  input  wire [15:0] sig_op1,
  input  wire [15:0] sig_ref,
  input  wire        p45_user_oe,
  output wire        alt_boot_mode,
  output wire        bootstrap_loader_mode,
  output wire        normal_mode,
  output wire        test_flash_mapped,
  output reg  [15:0] system_config_reg,
  output reg  [15:0] ext_periph_select_reg,
  output reg  [15:0] bus_control_zero_reg,
  output reg  [15:0] context_pointer,
  output reg  [15:0] stack_pointer,
  output reg  [15:0] stack_underflow_limit,
  output reg  [15:0] stack_overflow_limit,
  output wire [15:0] emulation_control_reg,
  output wire        watchdog_disable,
  output reg         sw_reset_pulse,
  output wire        acc_allow,
  output wire        prog_allow,
  output reg         sig_done,
  output reg         sig_ok,
  output reg         user_code_go,
  output reg  [23:0] boot_start_addr,
  output wire        port_four_bit_five_oe
);

  // One-hot sequencer states
  localparam [3:0] ST_HOLD = 4'b0001;
  localparam [3:0] ST_INIT = 4'b0010;
  localparam [3:0] ST_SIG  = 4'b0100;
  localparam [3:0] ST_RUN  = 4'b1000;

  function in_range;
    input [23:0] a;
    input [23:0] lo;
    input [23:0] hi;
    begin
      in_range = (a >= lo) && (a <= hi);
    end
  endfunction

  reg  [2:0]  rstpin_sync_ff;
  reg  [7:0]  p0_meta_ff;
  reg  [7:0]  p0_sync_ff;
  reg  [1:0]  ea_sync_ff;
  reg  [1:0]  mode_ff;
  reg  [1:0]  bus_type_field_ff;
  reg         ea_low_ff;
  reg         abm_flag_ff;
  reg         end_of_init_instruction_done_ff;
  reg  [3:0]  state_ff;
  reg  [3:0]  nxt_state;
  reg  [15:0] sig_sum;
  reg  [15:0] sig_val;
  wire        pin_rise;
  wire        boot_any;
  wire        ext_periph_enable_bit;
  wire        rd_ok;
  wire        fl_ok;
  wire        ram_ok;
  wire        per_ok;

  // Reset pin: two stages, third stage only for edge detect
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rstpin_sync_ff <= 3'h0;
      p0_meta_ff     <= 8'hff;
      p0_sync_ff     <= 8'hff;
      ea_sync_ff     <= 2'h3;
    end else begin
      rstpin_sync_ff <= {rstpin_sync_ff[1:0], reset_input_pin_n};
      p0_meta_ff     <= port_zero_low_config;
      p0_sync_ff     <= p0_meta_ff;
      ea_sync_ff     <= {ea_sync_ff[0], external_access_pin_n};
    end
  end

  assign pin_rise = rstpin_sync_ff[1] & ~rstpin_sync_ff[2];

  // Strap capture at pin release; frozen until next reset
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode_ff     <= `BMSI_MODE_NORMAL;
      bus_type_field_ff     <= 2'h0;
      ea_low_ff   <= 1'b0;
      abm_flag_ff <= 1'b0;
    end else if (pin_rise) begin
      mode_ff     <= p0_sync_ff[`BMSI_MODE_HI:`BMSI_MODE_LO];
      bus_type_field_ff     <= p0_sync_ff[`BMSI_BUS_TYPE_FIELD_HI:`BMSI_BUS_TYPE_FIELD_LO];
      ea_low_ff   <= ~ea_sync_ff[1];
      abm_flag_ff <= (p0_sync_ff[`BMSI_MODE_HI:`BMSI_MODE_LO] == `BMSI_MODE_ALT);
    end else if (sw_reset_pulse) begin
      // Software reset drops boot mode; pins are not resampled
      mode_ff     <= `BMSI_MODE_NORMAL;
      abm_flag_ff <= 1'b0;
    end
  end

  assign alt_boot_mode         = (mode_ff == `BMSI_MODE_ALT);
  assign bootstrap_loader_mode = (mode_ff == `BMSI_MODE_BSL);
  assign normal_mode           = (mode_ff == `BMSI_MODE_NORMAL);
  assign boot_any              = alt_boot_mode | bootstrap_loader_mode;
  assign test_flash_mapped     = boot_any;
  assign watchdog_disable      = boot_any;
  assign emulation_control_reg = {10'h000, abm_flag_ff, 5'h00};
  assign port_four_bit_five_oe = p45_user_oe & ~boot_any;

  // Watchdog reset in a boot mode is turned into a software reset
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sw_reset_pulse <= 1'b0;
    end else begin
      sw_reset_pulse <= sw_reset_req | (wdt_reset_req & boot_any);
    end
  end

  // Sequencer: hold while pin low, init, signature, run
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_HOLD: begin
        if (pin_rise) begin
          nxt_state = ST_INIT;
        end
      end
      ST_INIT: begin
        nxt_state = alt_boot_mode ? ST_SIG : ST_RUN;
      end
      ST_SIG: begin
        if (sig_done) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        nxt_state = ST_RUN;
      end
      default: begin
        nxt_state = ST_HOLD;
      end
    endcase
    if (!rstpin_sync_ff[1]) begin
      nxt_state = ST_HOLD;
    end else if (sw_reset_pulse) begin
      nxt_state = ST_INIT;
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_HOLD;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Signature: sum, low byte inverted, compared to reference
  always @* begin
    sig_sum = sig_op0 + sig_op1;
    sig_val = {sig_sum[15:8], ~sig_sum[7:0]};
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sig_done     <= 1'b0;
      sig_ok       <= 1'b0;
      user_code_go <= 1'b0;
    end else if (state_ff != ST_SIG && state_ff != ST_RUN) begin
      sig_done     <= 1'b0;
      sig_ok       <= 1'b0;
      user_code_go <= 1'b0;
    end else if (state_ff == ST_SIG && sig_start && !sig_done) begin
      sig_done     <= 1'b1;
      sig_ok       <= (sig_val == sig_ref);
      user_code_go <= (sig_val == sig_ref);
    end
  end

  // Boot register loads; software writes allowed until end-of-init
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      system_config_reg     <= `BMSI_ZERO16;
      ext_periph_select_reg <= `BMSI_ZERO16;
      bus_control_zero_reg  <= `BMSI_ZERO16;
      context_pointer       <= `BMSI_ZERO16;
      stack_pointer         <= `BMSI_ZERO16;
      stack_underflow_limit <= `BMSI_ZERO16;
      stack_overflow_limit  <= `BMSI_ZERO16;
      boot_start_addr       <= `BMSI_STD_START;
      end_of_init_instruction_done_ff         <= 1'b0;
    end else if (state_ff == ST_INIT) begin
      end_of_init_instruction_done_ff <= 1'b0;
      bus_control_zero_reg <= `BMSI_ZERO16;
      if (ea_low_ff) begin
        bus_control_zero_reg[`BMSI_BUS_ACT] <= 1'b1;
        bus_control_zero_reg[`BMSI_BUS_ALE] <= 1'b1;
        bus_control_zero_reg[`BMSI_BUS_TYP_HI:`BMSI_BUS_TYP_LO] <= bus_type_field_ff;
      end
      if (boot_any) begin
        context_pointer       <= `BMSI_CP_BOOT;
        stack_pointer         <= `BMSI_SP_BOOT;
        stack_underflow_limit <= `BMSI_STACK_UNDERFLOW_LIMIT_BOOT;
        stack_overflow_limit  <= `BMSI_STACK_OVERFLOW_LIMIT_BOOT;
        ext_periph_select_reg <= `BMSI_XPER_BOOT;
        system_config_reg     <= `BMSI_SYSTEM_CONFIG_REG_BOOT;
        // Narrow bus types 00/01 need the high byte disabled
        system_config_reg[`BMSI_SYS_BYTE_HIGH_DISABLE_BIT] <= ~bus_type_field_ff[1];
      end else begin
        context_pointer       <= `BMSI_ZERO16;
        stack_pointer         <= `BMSI_ZERO16;
        stack_underflow_limit <= `BMSI_ZERO16;
        stack_overflow_limit  <= `BMSI_ZERO16;
        ext_periph_select_reg <= `BMSI_ZERO16;
        system_config_reg     <= `BMSI_ZERO16;
        system_config_reg[`BMSI_SYS_INTERNAL_MEM_ENABLE_BIT] <= ~ea_low_ff;
      end
      boot_start_addr <= alt_boot_mode ? `BMSI_ALT_START : `BMSI_STD_START;
    end else if (!end_of_init_instruction_done_ff) begin
      if (end_of_init_instruction_exec) begin
        end_of_init_instruction_done_ff <= 1'b1;
      end
      if (system_config_reg_wr) begin
        system_config_reg <= cfg_wdata;
        if (boot_any) begin
          system_config_reg[`BMSI_SYS_INTERNAL_MEM_ENABLE_BIT] <= 1'b1;
        end
      end
      // Selection only takes while the enable bit is clear
      if (xper_wr && !ext_periph_enable_bit) begin
        ext_periph_select_reg <= cfg_wdata;
      end
    end
  end

  // Access filter: fetch barred from primary flash in boot modes
  assign ext_periph_enable_bit   = system_config_reg[`BMSI_SYS_EXT_PERIPH_ENABLE_BIT];
  assign fl_ok  = ext_periph_enable_bit & ext_periph_select_reg[`BMSI_XP_EXTENSION_USER_FLASH];
  assign ram_ok = ext_periph_enable_bit & (ext_periph_select_reg[`BMSI_XP_XRAM1] |
                          ext_periph_select_reg[`BMSI_XP_XRAM2]);
  assign per_ok = ext_periph_enable_bit & ext_periph_select_reg[`BMSI_XP_CAN1];
  assign rd_ok  =
    in_range(acc_addr, `BMSI_IFL_LO, `BMSI_IFL_HI) ? ~(boot_any & acc_fetch) :
    in_range(acc_addr, `BMSI_XFL_LO, `BMSI_XFL_HI) ? fl_ok :
    in_range(acc_addr, `BMSI_EXTENSION_RAM_LO, `BMSI_EXTENSION_RAM_HI) ? ram_ok :
    in_range(acc_addr, `BMSI_XPER_LO, `BMSI_XPER_HI) ? per_ok :
    in_range(acc_addr, `BMSI_TFL_LO, `BMSI_TFL_HI) ? boot_any :
    1'b1;
  assign acc_allow = acc_valid & rd_ok;

  // Programming window, alternate boot only: all user flash but bank 2 block 0
  assign prog_allow = prog_req & alt_boot_mode &
                      (in_range(prog_addr, `BMSI_IFL_LO, `BMSI_IFL_HI) |
                       in_range(prog_addr, `BMSI_XFL_LO, `BMSI_XFL_HI)) &
                      ~in_range(prog_addr, `BMSI_B2B0_LO, `BMSI_B2B0_HI);

endmodule

//--- testbench/bmsi_boot_init_asserts.sv
`include "bmsi_defs.vh"
module bmsi_boot_init_chk (
  input wire        sys_clk,
  input wire        rst,
  input wire        reset_input_pin_n,
  input wire        sw_reset_req,
  input wire        wdt_reset_req,
  input wire        acc_valid,
  input wire [23:0] acc_addr,
  input wire        acc_fetch,
  input wire        prog_req,
  input wire [23:0] prog_addr,
  input wire        sig_start,
  input wire [15:0] sig_op0,
  input wire [15:0] sig_op1,
  input wire [15:0] sig_ref,
  input wire        alt_boot_mode,
  input wire        bootstrap_loader_mode,
  input wire        test_flash_mapped,
  input wire [15:0] system_config_reg,
  input wire [15:0] emulation_control_reg,
  input wire        watchdog_disable,
  input wire        sw_reset_pulse,
  input wire        acc_allow,
  input wire        prog_allow,
  input wire        sig_done,
  input wire        sig_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  // Helpers; settled waits out the strap latch after any reset edge
  wire        boot = alt_boot_mode | bootstrap_loader_mode;
  wire [15:0] sum = sig_op0 + sig_op1;
  wire        sig_good = {sum[15:8], ~sum[7:0]} == sig_ref;
  wire        in_ifl = acc_addr >= `BMSI_IFL_LO && acc_addr <= `BMSI_IFL_HI;
  wire        in_b20 = prog_addr >= `BMSI_B2B0_LO && prog_addr <= `BMSI_B2B0_HI;
  wire        quiet = !sw_reset_req && !wdt_reset_req && !sw_reset_pulse;
  wire        settled = reset_input_pin_n && !rst;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_wdt_off: assert property (watchdog_disable == boot)
    else $error("watchdog not held off");
  chk_tflash_map: assert property (test_flash_mapped == boot)
    else $error("test flash map wrong");
  chk_no_fetch: assert property (boot && acc_valid && acc_fetch && in_ifl |-> !acc_allow)
    else $error("fetch from primary flash allowed");
  chk_bank_lock: assert property (alt_boot_mode && prog_req && in_b20 |-> !prog_allow)
    else $error("locked block programmable");
  chk_internal_mem_enable_bit_forced: assert property (boot && $past(boot) |-> system_config_reg[10])
    else $error("memory enable clear in boot");
  chk_wdt_to_sw: assert property (boot && wdt_reset_req |=> sw_reset_pulse)
    else $error("watchdog reset not made software reset");
  chk_mode_hold: assert property (
    settled[*8] ##0 quiet |=> $stable({alt_boot_mode, bootstrap_loader_mode}))
    else $error("mode moved without reset");
  chk_sig_answer: assert property (
    settled[*8] ##0 (alt_boot_mode && sig_start && !sig_done)
    |=> sig_done && sig_ok == $past(sig_good)) else $error("signature result wrong");
  chk_abm_flag: assert property (emulation_control_reg == {10'h0, alt_boot_mode, 5'h0})
    else $error("alternate flag wrong");
  cover property ($rose(alt_boot_mode));
  cover property (sig_ok);
  cover property (sw_reset_pulse);
endmodule
bind bmsi_boot_init bmsi_boot_init_chk u_chk (.*);

//--- testbench/bmsi_pins_model.sv
module bmsi_pins_model (
  input  wire        sys_clk,
  output logic       reset_input_pin_n,
  output logic [7:0] port_zero_low_config,
  output logic       external_access_pin_n,
  output wire        can_one_receive_line
);
  timeunit 1ns;
  timeprecision 1ps;
  // Board pull-up keeps CAN receive idle high
  assign can_one_receive_line = 1'h1;
  initial begin
    reset_input_pin_n = 1'h0;
    port_zero_low_config = 8'hff;
    external_access_pin_n = 1'h1;
  end
  // Straps wander once held long enough, so a late resample shows up
  task automatic boot(input logic [1:0] m, input logic ea, input logic [1:0] bt);
    @(posedge sys_clk);
    #1;
    reset_input_pin_n = 1'h0;
    port_zero_low_config = {bt, m, 4'h5};
    external_access_pin_n = ea;
    repeat (4) @(posedge sys_clk);
    #1;
    reset_input_pin_n = 1'h1;
    repeat (6) @(posedge sys_clk);
    #1;
    port_zero_low_config = ~port_zero_low_config;
    external_access_pin_n = ~ea;
  endtask
endmodule

//--- testbench/tb_bmsi_boot_init.sv
module tb_bmsi_boot_init;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'h0, rst = 1'h1, sw_reset_req = 1'h0, wdt_reset_req = 1'h0, b;
  logic end_of_init_instruction_exec = 1'h0, system_config_reg_wr = 1'h0, xper_wr = 1'h0, acc_valid = 1'h0;
  logic acc_fetch = 1'h0, prog_req = 1'h0, sig_start = 1'h0, p45_user_oe = 1'h0;
  logic [15:0] cfg_wdata = '0, sig_op0 = '0, sig_op1 = '0, sig_ref = '0, s, w;
  logic [23:0] acc_addr = '0, prog_addr = '0;
  logic [1:0] bt;
  wire reset_input_pin_n, external_access_pin_n, can_one_receive_line;
  wire [7:0] port_zero_low_config;
  wire alt_boot_mode, bootstrap_loader_mode, normal_mode, test_flash_mapped, watchdog_disable;
  wire sw_reset_pulse, acc_allow, prog_allow, sig_done, sig_ok, user_code_go;
  wire port_four_bit_five_oe;
  wire [15:0] system_config_reg, ext_periph_select_reg, bus_control_zero_reg, context_pointer;
  wire [15:0] stack_pointer, stack_underflow_limit, stack_overflow_limit, emulation_control_reg;
  wire [23:0] boot_start_addr;
  int n_errors = 0, n_tests = 0, seed = 16590, sel_m;
  int q_s[$];
  logic [63:0] q_v[$];
  bmsi_boot_init dut (.*);
  bmsi_pins_model pm (.*);
  always #2 sys_clk = ~sys_clk;
  task automatic tick(int n = 1);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic ex(int sel, logic [63:0] v);
    q_s.push_back(sel);
    q_v.push_back(v);
  endtask
  function automatic logic [63:0] obs(int sel);
    case (sel)
      0: return {alt_boot_mode, bootstrap_loader_mode, normal_mode};
      1: return system_config_reg;
      2: return ext_periph_select_reg;
      3: return bus_control_zero_reg;
      4: return {context_pointer, stack_pointer, stack_underflow_limit, stack_overflow_limit};
      8: return emulation_control_reg;
      9: return {watchdog_disable, test_flash_mapped};
      10: return sw_reset_pulse;
      11: return acc_allow;
      12: return prog_allow;
      13: return {sig_done, sig_ok, user_code_go};
      14: return boot_start_addr;
      default: return port_four_bit_five_oe;
    endcase
  endfunction
  task automatic check(int sel, logic [63:0] seen, logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch out%0d exp %h seen %h", sel, exp, seen);
    end
  endtask
  // Outputs are settled by the falling edge; oldest note first
  always @(negedge sys_clk) begin
    while (q_s.size() > 0) begin
      sel_m = q_s.pop_front();
      check(sel_m, obs(sel_m), q_v.pop_front());
    end
  end
  task automatic acc(logic [23:0] a, logic f, logic e);
    acc_valid = 1'h1;
    acc_addr = a;
    acc_fetch = f;
    ex(11, e);
    tick;
  endtask
  // Strobes dropped then a spare cycle, so calls can follow directly
  task automatic cfg(logic sy, logic [15:0] d, logic ei);
    system_config_reg_wr = sy;
    xper_wr = !sy;
    cfg_wdata = d;
    end_of_init_instruction_exec = ei;
    tick;
    system_config_reg_wr = 1'h0;
    xper_wr = 1'h0;
    end_of_init_instruction_exec = 1'h0;
    tick;
  endtask
  task automatic report_and_stop;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    tick(16);
    rst = 1'h0;
    // Strap codes 1 to 3; access pin follows the low code bit
    for (int i = 1; i < 4; i++) begin
      bt = 2'($random(seed));
      pm.boot(i[1:0], i[0], bt);
      b = i != 3;
      tick(3);
      ex(0, {i == 1, i == 2, i == 3});
      ex(9, {b, b});
      ex(8, {i == 1, 5'h0});
      ex(1, b ? {5'h0, 1'h1, !bt[1], 9'h4} : {5'h0, i[0], 10'h0});
      ex(3, i[0] ? 16'h0 : {5'h0, 2'h3, 1'h0, bt, 6'h0});
      ex(4, b ? 64'hfa00_fa40_fa00_fc00 : 64'h0);
      ex(2, b ? 16'h2d : 16'h0);
      p45_user_oe = 1'h1;
      wdt_reset_req = 1'h1;
      ex(15, !b);
      tick;
      wdt_reset_req = 1'h0;
      ex(10, b);
      tick(2);
      ex(0, 3'h1);
      $display("test strap code %0d done", i);
    end
    // Alternate boot: bad signature first, then a good one
    for (int k = 1; k >= 0; k--) begin
      bt = 2'($random(seed));
      pm.boot(2'h1, 1'h1, bt);
      tick(3);
      sig_op0 = 16'($random(seed));
      sig_op1 = 16'($random(seed));
      s = sig_op0 + sig_op1;
      sig_ref = {s[15:8], ~s[7:0]} ^ k[15:0];
      sig_start = 1'h1;
      tick;
      sig_start = 1'h0;
      ex(13, {1'h1, k == 0, k == 0});
    end
    ex(14, 24'h090000);
    w = {6'h0, !bt[1], 9'h0};
    acc(24'h010000, 1'h1, 1'h0);
    acc(24'h010000, 1'h0, 1'h1);
    acc(24'h090000, 1'h1, 1'h1);
    acc(24'h000000, 1'h1, 1'h1);
    prog_req = 1'h1;
    for (int j = 0; j < 4; j++) begin
      prog_addr = (j > 1 ? 24'h0c3fff : 24'h0bffff) + j[0];
      ex(12, j[0] == j[1]);
      tick;
    end
    // Selection change: drop enable, select, re-enable with init end
    cfg(1'h1, w, 1'h0);
    ex(1, w | 16'h0400);
    acc(24'h090000, 1'h1, 1'h0);
    cfg(1'h0, 16'h21, 1'h0);
    ex(2, 16'h21);
    cfg(1'h1, w | 16'h4, 1'h1);
    acc(24'h0e0000, 1'h0, 1'h0);
    acc(24'h090000, 1'h1, 1'h1);
    cfg(1'h1, 16'h0, 1'h0);
    ex(1, w | 16'h0404);
    tick;
    // A software reset request drops alternate mode back to normal
    sw_reset_req = 1'h1;
    tick;
    sw_reset_req = 1'h0;
    ex(10, 1'h1);
    tick(2);
    ex(0, 3'h1);
    ex(8, 6'h0);
    ex(14, 24'h0);
    // Normal mode again: primary flash fetch allowed, test flash barred
    acc(24'h010000, 1'h1, 1'h1);
    acc(24'h000000, 1'h1, 1'h0);
    $display("test alternate boot done");
    report_and_stop;
  end
endmodule
